// >>> fsic_top.sv
`timescale 1ns/1ns
`default_nettype none
module fsic_top #(
  parameter int SUSPEND_GAP = fsic_pkg::SUSPEND_GAP_CYCLES
) (
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  output logic                         IRQ,
  output fsic_pkg::fsic_arr_req_t      ARR_REQ,
  input  wire fsic_pkg::fsic_arr_rsp_t ARR_RSP,
  input  wire logic                    PE_BUSY,
  output logic                         PE_SUSPEND
);
  localparam int MARGIN_DLY = fsic_pkg::MARGIN_CYCLES;

  fsic_pkg::fsic_state_t   state, next_state;
  fsic_pkg::fsic_arr_req_t next_req;
  logic [2:0]  read_wait_states, next_rws;
  logic [1:0]  address_pipeline_setting, next_aps;
  logic        bp_en, next_bp_en, margin, next_margin;
  logic [15:0] start_addr, next_start, end_addr, next_end;
  logic [15:0] cur, next_cur, event_addr, next_event_addr;
  logic        event_seen, next_event_seen;
  logic [7:0]  wcnt, next_wcnt;
  logic [fsic_pkg::INT_W-1:0] int_stat, next_int_stat, int_mask, next_int_mask, ev_set;
  logic        susp_pend, next_susp_pend, next_pe_suspend;
  logic [12:0] gap_cnt, next_gap_cnt;
  logic [31:0] next_prdata, rdval;
  logic        next_pready, next_pslverr, mapped, acc, wr;
  logic        sig_clear, sig_shift, ev, ctl_wr;
  logic [31:0] sig;

  fsic_sig #(.W(32), .POLY(fsic_pkg::SIG_POLY)) u_sig (
    .clk   (CLK),
    .nrst  (NRST),
    .clear (sig_clear),
    .shift (sig_shift),
    .data  (ARR_RSP.data),
    .sig   (sig)
  );

  // the write lands on the edge where the master sees pready
  assign acc    = PSEL && PENABLE && PREADY;
  assign wr     = acc && PWRITE;
  assign ctl_wr = wr && (PADDR == fsic_pkg::OFS_CTRL);
  assign ev     = ARR_RSP.ecc_event_error || ARR_RSP.single_bit_correction;

  always_comb begin
    mapped = 1'b1;
    rdval  = 32'h0000_0000;
    unique case (PADDR)
      fsic_pkg::OFS_CTRL:      rdval = {30'h0, margin, bp_en} << fsic_pkg::CTL_BP_EN;
      fsic_pkg::OFS_CONFIG:    rdval = {26'h0, address_pipeline_setting, 1'b0, read_wait_states};
      fsic_pkg::OFS_START:     rdval = {16'h0, start_addr};
      fsic_pkg::OFS_END:       rdval = {16'h0, end_addr};
      fsic_pkg::OFS_STATUS:    rdval = {27'h0, event_seen, susp_pend, PE_SUSPEND,
                                        state == fsic_pkg::FSIC_HALT,
                                        state != fsic_pkg::FSIC_IDLE};
      fsic_pkg::OFS_SIGNATURE: rdval = sig;
      fsic_pkg::OFS_EVT_ADDR:  rdval = {16'h0, event_addr};
      fsic_pkg::OFS_INT_STAT:  rdval = {27'h0, int_stat};
      fsic_pkg::OFS_INT_MASK:  rdval = {27'h0, int_mask};
      default:                 mapped = 1'b0;
    endcase
    next_pready  = PSEL && PENABLE && !PREADY;
    next_prdata  = next_pready && !PWRITE ? rdval : 32'h0000_0000;
    next_pslverr = next_pready && !mapped;
  end

  always_comb begin
    next_state      = state;
    next_rws        = read_wait_states;
    next_aps        = address_pipeline_setting;
    next_bp_en      = bp_en;
    next_margin     = margin;
    next_start      = start_addr;
    next_end        = end_addr;
    next_cur        = cur;
    next_wcnt       = wcnt;
    next_event_addr = event_addr;
    next_event_seen = event_seen;
    next_int_mask   = int_mask;
    next_susp_pend  = susp_pend;
    next_pe_suspend = PE_SUSPEND;
    next_gap_cnt    = gap_cnt != 13'h0 ? gap_cnt - 13'h1 : gap_cnt;
    ev_set          = '0;
    sig_clear       = 1'b0;
    sig_shift       = 1'b0;

    if (wr) begin
      unique case (PADDR)
        fsic_pkg::OFS_CTRL: begin
          next_bp_en  = PWDATA[fsic_pkg::CTL_BP_EN];
          next_margin = PWDATA[fsic_pkg::CTL_MARGIN];
        end
        fsic_pkg::OFS_CONFIG: begin
          next_rws = PWDATA[fsic_pkg::CFG_RWS_LSB +: 3];
          next_aps = PWDATA[fsic_pkg::CFG_APS_LSB +: 2];
        end
        fsic_pkg::OFS_START:    next_start    = PWDATA[15:0];
        fsic_pkg::OFS_END:      next_end      = PWDATA[15:0];
        fsic_pkg::OFS_INT_MASK: next_int_mask = PWDATA[fsic_pkg::INT_W-1:0];
        default: ;
      endcase
    end

    // suspend guard: a request inside the gap waits rather than reaching the engine
    if (ctl_wr && PWDATA[fsic_pkg::CTL_SUSPEND] && PE_BUSY && !PE_SUSPEND) begin
      next_susp_pend = 1'b1;
      if (gap_cnt != 13'h0) begin
        ev_set[fsic_pkg::IRQ_DEFER] = 1'b1;
      end
    end
    if (ctl_wr && PWDATA[fsic_pkg::CTL_RESUME]) begin
      next_pe_suspend = 1'b0;
      next_susp_pend  = 1'b0;
    end else if (susp_pend && gap_cnt == 13'h0) begin
      next_pe_suspend = 1'b1;
      next_susp_pend  = 1'b0;
      next_gap_cnt    = 13'(SUSPEND_GAP - 1);
    end

    unique case (state)
      fsic_pkg::FSIC_IDLE: begin
        if (ctl_wr && PWDATA[fsic_pkg::CTL_START]) begin
          next_state      = fsic_pkg::FSIC_READ;
          next_cur        = start_addr;
          next_margin     = PWDATA[fsic_pkg::CTL_MARGIN];
          next_bp_en      = PWDATA[fsic_pkg::CTL_BP_EN];
          next_wcnt       = PWDATA[fsic_pkg::CTL_MARGIN] ? 8'(MARGIN_DLY - 1)
                                                         : {5'h0, read_wait_states};
          next_event_seen = 1'b0;
          sig_clear       = 1'b1;
        end
      end
      fsic_pkg::FSIC_READ: begin
        if (wcnt != 8'h00) begin
          next_wcnt = wcnt - 8'h01;
        end else begin
          sig_shift = 1'b1;
          if (ev) begin
            ev_set[fsic_pkg::IRQ_ECC] = ARR_RSP.ecc_event_error;
            ev_set[fsic_pkg::IRQ_SBC] = ARR_RSP.single_bit_correction;
            if (!event_seen) begin
              next_event_seen = 1'b1;
              next_event_addr = cur;
            end
          end
          if (ev && bp_en) begin
            next_state                  = fsic_pkg::FSIC_HALT;
            ev_set[fsic_pkg::IRQ_BREAK] = 1'b1;
          end else if (cur == end_addr) begin
            next_state                 = fsic_pkg::FSIC_IDLE;
            ev_set[fsic_pkg::IRQ_DONE] = 1'b1;
          end else begin
            next_cur  = cur + 16'h0001;
            next_wcnt = margin ? 8'(MARGIN_DLY - 1) : {5'h0, read_wait_states};
          end
        end
      end
      fsic_pkg::FSIC_HALT: begin
        // the pointer only moves on continue, so the following address is read afresh
        if (ctl_wr && PWDATA[fsic_pkg::CTL_CONTINUE]) begin
          if (cur == end_addr) begin
            next_state                 = fsic_pkg::FSIC_IDLE;
            ev_set[fsic_pkg::IRQ_DONE] = 1'b1;
          end else begin
            next_state = fsic_pkg::FSIC_READ;
            next_cur   = cur + 16'h0001;
            next_wcnt  = margin ? 8'(MARGIN_DLY - 1) : {5'h0, read_wait_states};
          end
        end
      end
      default: next_state = fsic_pkg::FSIC_IDLE;
    endcase

    // set wins over a write-one clear in the same cycle
    next_int_stat = int_stat;
    if (wr && PADDR == fsic_pkg::OFS_INT_STAT) begin
      next_int_stat = int_stat & ~PWDATA[fsic_pkg::INT_W-1:0];
    end
    next_int_stat = next_int_stat | ev_set;

    next_req.valid   = next_state == fsic_pkg::FSIC_READ;
    next_req.margin  = next_margin;
    next_req.sample  = next_req.valid && next_wcnt == 8'h00;
    next_req.rd_addr = next_cur;
    // early address only for timed reads; margin reads never run ahead
    next_req.addr    = next_req.valid && !next_margin && next_cur != next_end &&
                       next_wcnt <= {6'h0, next_aps} ? next_cur + 16'h0001 : next_cur;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state                    <= fsic_pkg::FSIC_IDLE;
      read_wait_states         <= fsic_pkg::RWS_RESET;
      address_pipeline_setting <= fsic_pkg::APS_RESET;
      bp_en                    <= 1'b0;
      margin                   <= 1'b0;
      start_addr               <= 16'h0000;
      end_addr                 <= 16'h0000;
      cur                      <= 16'h0000;
      wcnt                     <= 8'h00;
      event_addr               <= 16'h0000;
      event_seen               <= 1'b0;
      int_stat                 <= '0;
      int_mask                 <= '0;
      susp_pend                <= 1'b0;
      gap_cnt                  <= 13'h0000;
      PE_SUSPEND               <= 1'b0;
      PRDATA                   <= 32'h0000_0000;
      PREADY                   <= 1'b0;
      PSLVERR                  <= 1'b0;
      IRQ                      <= 1'b0;
      ARR_REQ                  <= '0;
    end else begin
      state                    <= next_state;
      read_wait_states         <= next_rws;
      address_pipeline_setting <= next_aps;
      bp_en                    <= next_bp_en;
      margin                   <= next_margin;
      start_addr               <= next_start;
      end_addr                 <= next_end;
      cur                      <= next_cur;
      wcnt                     <= next_wcnt;
      event_addr               <= next_event_addr;
      event_seen               <= next_event_seen;
      int_stat                 <= next_int_stat;
      int_mask                 <= next_int_mask;
      susp_pend                <= next_susp_pend;
      gap_cnt                  <= next_gap_cnt;
      PE_SUSPEND               <= next_pe_suspend;
      PRDATA                   <= next_prdata;
      PREADY                   <= next_pready;
      PSLVERR                  <= next_pslverr;
      IRQ                      <= |(next_int_stat & next_int_mask);
      ARR_REQ                  <= next_req;
    end
  end

  sequence s_margin_start;
    ctl_wr && PWDATA[fsic_pkg::CTL_START] && PWDATA[fsic_pkg::CTL_MARGIN]
      && state == fsic_pkg::FSIC_IDLE;
  endsequence

  a_ready_single: assert property (@(posedge CLK) disable iff (!NRST)
    PREADY |=> !PREADY) else $error("pready held longer than one cycle");
  a_irq_follows: assert property (@(posedge CLK) disable iff (!NRST)
    (|(int_stat & int_mask)) |-> IRQ) else $error("irq low with unmasked status");
  a_suspend_gap: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(PE_SUSPEND) |-> $past(gap_cnt) == 13'h0) else $error("suspend issued inside gap");
  a_resume_release: assert property (@(posedge CLK) disable iff (!NRST)
    ctl_wr && PWDATA[fsic_pkg::CTL_RESUME] |=> !PE_SUSPEND) else $error("resume ignored");
  a_break_halts: assert property (@(posedge CLK) disable iff (!NRST)
    state == fsic_pkg::FSIC_READ && wcnt == 8'h00 && ev && bp_en
      |=> state == fsic_pkg::FSIC_HALT && int_stat[fsic_pkg::IRQ_BREAK])
    else $error("event with breakpoints did not halt");
  a_no_skip: assert property (@(posedge CLK) disable iff (!NRST)
    state == fsic_pkg::FSIC_HALT && next_state == fsic_pkg::FSIC_READ
      |=> cur == $past(cur) + 16'h0001) else $error("address skipped after breakpoint");
  a_margin_timed: assert property (@(posedge CLK) disable iff (!NRST)
    s_margin_start ##MARGIN_DLY 1'b1 |-> ARR_REQ.sample) else $error("margin read not self timed");
  a_first_logged: assert property (@(posedge CLK) disable iff (!NRST)
    event_seen && state != fsic_pkg::FSIC_IDLE |=> $stable(event_addr))
    else $error("first event address overwritten");
  a_wait_spacing: assert property (@(posedge CLK) disable iff (!NRST)
    ARR_REQ.sample && !margin && read_wait_states != 3'h0 && state == fsic_pkg::FSIC_READ
      |=> !ARR_REQ.sample) else $error("wait states not honoured");
endmodule
`default_nettype wire

// >>> fsic_pkg.sv
package fsic_pkg;
  localparam int CLK_MHZ            = 250;
  localparam int SUSPEND_GAP_US     = 20;
  localparam int SUSPEND_GAP_CYCLES = SUSPEND_GAP_US * CLK_MHZ;
  localparam int MARGIN_READ_NS     = 40;
  localparam int MARGIN_CYCLES      = (MARGIN_READ_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CONFIG    = 8'h04;
  localparam logic [7:0] OFS_START     = 8'h08;
  localparam logic [7:0] OFS_END       = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_SIGNATURE = 8'h14;
  localparam logic [7:0] OFS_EVT_ADDR  = 8'h18;
  localparam logic [7:0] OFS_INT_STAT  = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK  = 8'h20;

  // control register bits
  localparam int CTL_START    = 0;
  localparam int CTL_BP_EN    = 1;
  localparam int CTL_MARGIN   = 2;
  localparam int CTL_SUSPEND  = 3;
  localparam int CTL_RESUME   = 4;
  localparam int CTL_CONTINUE = 5;
  // config register fields
  localparam int CFG_RWS_LSB  = 0;
  localparam int CFG_APS_LSB  = 4;
  // interrupt status bits
  localparam int INT_W        = 5;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_BREAK    = 1;
  localparam int IRQ_ECC      = 2;
  localparam int IRQ_SBC      = 3;
  localparam int IRQ_DEFER    = 4;

  localparam logic [2:0] RWS_RESET = 3'h5;
  localparam logic [1:0] APS_RESET = 2'h2;
  localparam logic [31:0] SIG_POLY = 32'h04C11DB7;

  typedef enum logic [1:0] {FSIC_IDLE, FSIC_READ, FSIC_HALT} fsic_state_t;

  typedef struct packed {
    logic        valid;
    logic        margin;
    logic        sample;
    logic [15:0] rd_addr;
    logic [15:0] addr;
  } fsic_arr_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic        ecc_event_error;
    logic        single_bit_correction;
  } fsic_arr_rsp_t;
endpackage

// >>> fsic_sig.sv
`timescale 1ns/1ns
`default_nettype none
module fsic_sig #(
  parameter int          W    = 32,
  parameter logic [31:0] POLY = fsic_pkg::SIG_POLY
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         shift,
  input  wire logic [W-1:0] data,
  output logic      [W-1:0] sig
);
  logic [W-1:0] next_sig;
  logic [W-1:0] stepped;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (i == 0) begin : g_lsb
        assign stepped[i] = data[i] ^ sig[W-1];
      end else begin : g_up
        assign stepped[i] = data[i] ^ sig[i-1] ^ (sig[W-1] & POLY[i]);
      end
    end
  endgenerate

  always_comb begin
    next_sig = sig;
    if (clear) begin
      next_sig = '0;
    end else if (shift) begin
      next_sig = stepped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sig <= '0;
    end else begin
      sig <= next_sig;
    end
  end
endmodule
`default_nettype wire

// >>> fsic_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsic_flash_model #(
  parameter logic [15:0] ECC_ADDR = 16'h0012,
  parameter logic [15:0] SBC_ADDR = 16'h0013,
  parameter int          WORK     = 400
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire fsic_pkg::fsic_arr_req_t req,
  output fsic_pkg::fsic_arr_rsp_t      rsp,
  input  wire logic                    pe_go,
  input  wire logic                    pe_suspend,
  output logic                         pe_busy
);
  logic [31:0] junk;
  int          work_left;

  // outside a sample cycle data and flags flip every cycle, so a late sample never looks valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      junk <= 32'h5A5A5A5A;
    end else begin
      junk <= ~junk;
    end
  end

  always_comb begin
    rsp.data                  = junk;
    rsp.ecc_event_error       = junk[0];
    rsp.single_bit_correction = junk[1];
    if (req.sample) begin
      rsp.data                  = {~req.rd_addr, req.rd_addr};
      rsp.ecc_event_error       = (req.rd_addr == ECC_ADDR);
      rsp.single_bit_correction = (req.rd_addr == SBC_ADDR);
    end
  end

  // the engine only makes progress while not suspended and resumes where it left off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      work_left <= 0;
    end else if (pe_go) begin
      work_left <= WORK;
    end else if (work_left > 0 && !pe_suspend) begin
      work_left <= work_left - 1;
    end
  end

  assign pe_busy = (work_left > 0);
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
  localparam int GAP = 50;
  logic                    CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic                    PE_BUSY, PE_SUSPEND, pe_go, err, ps_q;
  logic [7:0]              PADDR;
  logic [31:0]             PWDATA, PRDATA, rd, sig, sig_bp;
  fsic_pkg::fsic_arr_req_t ARR_REQ;
  fsic_pkg::fsic_arr_rsp_t ARR_RSP;
  int                      mismatches, checks, cyc, last_smp, gap_last, g1, rise_q[$];
  logic [15:0]             addr_q[$];

  fsic_top #(.SUSPEND_GAP(GAP)) dut_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .ARR_REQ(ARR_REQ), .ARR_RSP(ARR_RSP),
    .PE_BUSY(PE_BUSY), .PE_SUSPEND(PE_SUSPEND));
  fsic_flash_model flash_u (.clk(CLK), .nrst(NRST), .req(ARR_REQ), .rsp(ARR_RSP),
    .pe_go(pe_go), .pe_suspend(PE_SUSPEND), .pe_busy(PE_BUSY));

  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end

  // monitor: address order, spacing of samples, suspend rises
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    ps_q <= PE_SUSPEND;
    if (PE_SUSPEND === 1'h1 && ps_q === 1'h0) rise_q.push_back(cyc);
    if (ARR_REQ.sample === 1'h1) begin
      addr_q.push_back(ARR_REQ.rd_addr);
      gap_last <= cyc - last_smp;
      last_smp <= cyc;
    end
    // timed reads put the following address out by the sample cycle, except at the end
    if (ARR_REQ.sample === 1'h1 && ARR_REQ.margin === 1'h0)
      `CHK(ARR_REQ.addr, ARR_REQ.rd_addr + {15'h0, ARR_REQ.rd_addr != 16'h17}, "early address")
    if (ARR_REQ.valid === 1'h1 && ARR_REQ.margin === 1'h1)
      `CHK(ARR_REQ.addr, ARR_REQ.rd_addr, "margin address ran ahead")
  end

  task automatic conclude();
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    @(posedge CLK);
    while (PREADY !== 1'h1 && n < 50) begin
      @(posedge CLK);
      n++;
    end
    `CHK(PREADY, 1'h1, "no ready")
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  task automatic t_reset_regs();
    `CHK(IRQ, 1'h0, "irq after reset")
    apb(1'h0, fsic_pkg::OFS_CONFIG, 32'h0);
    `CHK(rd, 32'h00000025, "config reset")
    apb(1'h1, 8'h40, 32'hFFFFFFFF);
    `CHK(err, 1'h1, "unmapped write")
    apb(1'h0, 8'h40, 32'h0);
    `CHK({err, rd}, {1'h1, 32'h0}, "unmapped read")
  endtask

  task automatic ai_run(input logic [2:0] rws, input logic [1:0] aps, input logic bp,
                        input logic mg, input int exp_halts);
    int          halts, n;
    logic [31:0] st;
    halts = 0;
    apb(1'h1, fsic_pkg::OFS_CONFIG, {26'h0, aps, 1'h0, rws});
    apb(1'h1, fsic_pkg::OFS_START, 32'h10);
    apb(1'h1, fsic_pkg::OFS_END, 32'h17);
    apb(1'h1, fsic_pkg::OFS_INT_MASK, 32'h3);
    addr_q.delete();
    apb(1'h1, fsic_pkg::OFS_CTRL, {29'h0, mg, bp, 1'h1});
    for (int k = 0; k < 6; k++) begin
      n = 0;
      while (IRQ !== 1'h1 && n < 3000) begin
        @(posedge CLK);
        n++;
      end
      `CHK(IRQ, 1'h1, "no interrupt")
      apb(1'h0, fsic_pkg::OFS_INT_STAT, 32'h0);
      st = rd;
      apb(1'h1, fsic_pkg::OFS_INT_STAT, st);
      if (st[fsic_pkg::IRQ_DONE] !== 1'h0) break;
      `CHK(st[3:1], (halts == 0) ? 3'h3 : 3'h5, "breakpoint cause")
      halts++;
      apb(1'h0, fsic_pkg::OFS_STATUS, 32'h0);
      `CHK(rd, 32'h00000013, "halted status")
      apb(1'h1, fsic_pkg::OFS_CTRL, {26'h0, 1'h1, 2'h0, mg, bp, 1'h0});
    end
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'h0, "irq after clear")
    apb(1'h0, fsic_pkg::OFS_STATUS, 32'h0);
    `CHK(rd, 32'h00000010, "idle status")
    `CHK(halts, exp_halts, "halt count")
    `CHK(addr_q.size(), 8, "read count")
    foreach (addr_q[i]) `CHK(addr_q[i], 16'h10 + i[15:0], "address order")
    apb(1'h0, fsic_pkg::OFS_SIGNATURE, 32'h0);
    sig = rd;
  endtask

  task automatic t_irq_mask();
    apb(1'h1, fsic_pkg::OFS_INT_MASK, 32'h0);
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h1);
    repeat (300) @(posedge CLK);
    `CHK(IRQ, 1'h0, "masked irq")
    apb(1'h0, fsic_pkg::OFS_INT_STAT, 32'h0);
    `CHK(rd[fsic_pkg::IRQ_DONE], 1'h1, "done sticky")
    apb(1'h1, fsic_pkg::OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'h1, "unmasked irq")
    apb(1'h1, fsic_pkg::OFS_INT_STAT, 32'h1F);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'h0, "cleared irq")
  endtask

  task automatic t_suspend();
    int n, spacing;
    pe_go <= 1'h1;
    @(posedge CLK);
    pe_go <= 1'h0;
    rise_q.delete();
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h8);
    repeat (3) @(posedge CLK);
    `CHK(PE_SUSPEND, 1'h1, "suspend")
    repeat (20) @(posedge CLK);
    `CHK(PE_BUSY, 1'h1, "held while suspended")
    apb(1'h0, fsic_pkg::OFS_STATUS, 32'h0);
    `CHK(rd, 32'h00000014, "suspended status")
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h10);
    // software breaks the spacing here on purpose: the second suspend must be held back
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h8);
    apb(1'h0, fsic_pkg::OFS_INT_STAT, 32'h0);
    `CHK(rd[fsic_pkg::IRQ_DEFER], 1'h1, "deferred flag")
    apb(1'h0, fsic_pkg::OFS_STATUS, 32'h0);
    `CHK(rd, 32'h00000018, "pending status")
    n = 0;
    while (rise_q.size() < 2 && n < 500) begin
      @(posedge CLK);
      n++;
    end
    spacing = (rise_q.size() == 2) ? rise_q[1] - rise_q[0] : 0;
    `CHK(spacing >= GAP && spacing <= GAP + 4, 1'h1, "suspend spacing")
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h10);
    n = 0;
    while (PE_BUSY !== 1'h0 && n < 1000) begin
      @(posedge CLK);
      n++;
    end
    `CHK(PE_BUSY, 1'h0, "operation finished")
    apb(1'h1, fsic_pkg::OFS_CTRL, 32'h8);
    repeat (4) @(posedge CLK);
    `CHK(PE_SUSPEND, 1'h0, "idle suspend ignored")
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    conclude();
  end

  initial begin
    {NRST, PSEL, PENABLE, PWRITE, pe_go} = 5'h0;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    {mismatches, checks, cyc, last_smp, gap_last} = '0;
    repeat (4) @(posedge CLK);
    NRST <= 1'h1;
    t_reset_regs();
    ai_run(3'h1, 2'h1, 1'h1, 1'h0, 2);
    sig_bp = sig;
    g1 = gap_last;
    ai_run(3'h3, 2'h2, 1'h1, 1'h0, 2);
    `CHK(sig, sig_bp, "signature with breakpoints")
    ai_run(3'h2, 2'h1, 1'h1, 1'h0, 2);
    `CHK(sig, sig_bp, "signature at recommended setting")
    ai_run(3'h5, 2'h3, 1'h0, 1'h0, 0);
    `CHK(sig, sig_bp, "signature without breakpoints")
    `CHK(gap_last - g1, 4, "wait state spacing")
    apb(1'h0, fsic_pkg::OFS_EVT_ADDR, 32'h0);
    `CHK(rd, 32'h12, "first event address")
    ai_run(3'h0, 2'h0, 1'h0, 1'h1, 0);
    `CHK(gap_last, fsic_pkg::MARGIN_CYCLES, "margin period")
    g1 = gap_last;
    ai_run(3'h7, 2'h0, 1'h0, 1'h1, 0);
    `CHK(gap_last, g1, "margin timing")
    `CHK(sig, sig_bp, "margin signature")
    t_irq_mask();
    t_suspend();
    conclude();
  end
endmodule
`default_nettype wire
